// ===== pkg/cttw_pkg.sv
// Shared constants and types for the transfer, test and wait sequencer.
package cttw_pkg;

	// ==========================================
	// Opcodes
	localparam logic [7:0] OP_FTEST = 8'h00;
	localparam logic [7:0] OP_LDFLG = 8'h06;
	localparam logic [7:0] OP_STFLG = 8'h07;
	localparam logic [7:0] OP_PFX   = 8'h18;
	localparam logic [7:0] OP_SPIX  = 8'h30;
	localparam logic [7:0] OP_IXSP  = 8'h35;
	localparam logic [7:0] OP_HALT  = 8'h3E;
	localparam logic [7:0] OP_CHKA  = 8'h4D;
	localparam logic [7:0] OP_CHKB  = 8'h5D;
	localparam logic [7:0] OP_CHKI  = 8'h6D;
	localparam logic [7:0] OP_CHKE  = 8'h7D;

	// ==========================================
	// Cycle counts, opcode fetch included; CYC_PUSH is the first stacking cycle of a halt
	localparam logic [4:0] CYC_INH  = 5'h02;
	localparam logic [4:0] CYC_SPX  = 5'h03;
	localparam logic [4:0] CYC_SPY  = 5'h04;
	localparam logic [4:0] CYC_CHKX = 5'h06;
	localparam logic [4:0] CYC_CHKE = 5'h06;
	localparam logic [4:0] CYC_CHKY = 5'h07;
	localparam logic [4:0] CYC_STK  = 5'h0C;
	localparam logic [4:0] CYC_PUSH = 5'h03;

	// ==========================================
	// Register indices on the software port
	localparam logic [3:0] RI_A    = 4'h0;
	localparam logic [3:0] RI_B    = 4'h1;
	localparam logic [3:0] RI_FLG  = 4'h2;
	localparam logic [3:0] RI_X    = 4'h3;
	localparam logic [3:0] RI_Y    = 4'h4;
	localparam logic [3:0] RI_SP   = 4'h5;
	localparam logic [3:0] RI_PC   = 4'h6;
	localparam logic [3:0] RI_STAT = 4'h7;
	localparam logic [3:0] RI_CTRL = 4'h8;
	localparam logic [3:0] RI_FSEL = 4'h9;
	localparam logic [3:0] RI_FOPD = 4'hA;
	localparam logic [3:0] RI_FRES = 4'hB;

	// ==========================================
	// Reset values
	localparam logic [7:0]  RST_FLG = 8'hD0;
	localparam logic [15:0] RST_SP  = 16'h00FF;
	localparam logic [15:0] RST_PC  = 16'h0000;

	// ==========================================
	// Flag bit positions
	localparam int FB_S = 7;
	localparam int FB_X = 6;
	localparam int FB_I = 4;
	localparam int FB_N = 3;
	localparam int FB_Z = 2;
	localparam int FB_V = 1;
	localparam int FB_C = 0;

	// ==========================================
	// Operand format selector codes
	localparam logic [2:0] FM_DIR = 3'h0;
	localparam logic [2:0] FM_IDX = 3'h1;
	localparam logic [2:0] FM_IDY = 3'h2;
	localparam logic [2:0] FM_EXT = 3'h3;
	localparam logic [2:0] FM_IMM = 3'h4;
	localparam logic [2:0] FM_REL = 3'h5;
	localparam logic [2:0] FM_MSK = 3'h6;

	// ==========================================
	// Sequencer states
	typedef enum logic [4:0] {
		ST_FETCH = 5'h01,
		ST_EXEC  = 5'h02,
		ST_WAIT  = 5'h04,
		ST_VEC   = 5'h08,
		ST_TEST  = 5'h10
	} cttw_state_t;

endpackage : cttw_pkg

// ===== design/cttw_core.sv
// Sequencer for flag transfers, zero checks, stack transfers, halt and test.
//
// What this block does
// RULE_01 - Opcode 06 copies A into flags, two cycles.
// RULE_02 - That copy may clear X mask, never set.
// RULE_03 - Opcode 07 copies flags into A, two cycles.
// RULE_04 - Memory check sets N Z, clears V C.
// RULE_05 - Opcode 4D checks A in two cycles.
// RULE_06 - Opcode 5D checks B in two cycles.
// RULE_07 - Opcode 30 loads X with SP plus one.
// RULE_08 - Opcode 18 30 loads Y with SP plus one.
// RULE_09 - Opcode 35 loads SP with X minus one.
// RULE_10 - Opcode 18 35 loads SP with Y minus one.
// RULE_11 - Halt stacks twelve cycles, waits, fetches vector.
// RULE_12 - Opcode 00 honoured only in test mode.
// RULE_13 - Test opcode increments address until reset.
// RULE_14 - Direct operand forms address with zero high byte.
// RULE_15 - Indexed adds unsigned byte to index register.
// RULE_16 - Extended address fetched high byte first.
// RULE_17 - Sixteen bit immediate fetched high byte first.
// RULE_18 - Relative offset sign extended from following address.
// RULE_19 - Mask byte selects only the affected bits.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
module cttw_core
	import cttw_pkg::*;
#(
	parameter logic [15:0] VEC_ADDR = 16'hFFF2
)(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Program memory bus
	output logic [15:0]      mem_addr,
	output logic             mem_rd,
	output logic             mem_we,
	output logic [7:0]       mem_wdata,
	input  wire logic [7:0]  mem_rdata,
	// Pins
	input  wire logic        irq_n_pin,
	input  wire logic        test_mode_pin,
	output logic             halted,
	// Software register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [15:0]      reg_rdata
);

	// ==========================================
	// State
	cttw_state_t st_r, st_nxt;
	logic [4:0]  cyc_r, cyc_nxt;
	logic [7:0]  op_r, op_nxt, a_r, a_nxt, b_r, b_nxt;
	logic [7:0]  flg_r, flg_nxt, hi_r, hi_nxt, lo_r, lo_nxt;
	logic [7:0]  m_r, m_nxt;
	logic [15:0] x_r, x_nxt, y_r, y_nxt, sp_r, sp_nxt;
	logic [15:0] pc_r, pc_nxt, tad_r, tad_nxt;
	logic        pfx_r, pfx_nxt, run_r, bad_r, bad_nxt;
	logic [2:0]  fsel_r;
	logic [15:0] fopd_r;
	logic        irq_s1_r, irq_s2_r, tm_s1_r, tm_s2_r;

	// Pins cross into the clock domain through two flops each.
	always_ff @(posedge clk)
	begin
		irq_s1_r <= irq_n_pin;
		irq_s2_r <= irq_s1_r;
		tm_s1_r  <= test_mode_pin;
		tm_s2_r  <= tm_s1_r;
	end

	// ==========================================
	// Decode
	wire        irq_go  = !irq_s2_r && !flg_r[FB_I];
	wire        sw_wr   = reg_wr;
	wire [4:0]  ol      = pfx_r ? 5'h02 : 5'h01;
	wire        is_ext  = op_r == OP_CHKE && !pfx_r;
	wire        is_ind  = op_r == OP_CHKI;
	wire        is_halt = op_r == OP_HALT && !pfx_r;
	wire        in_fet  = st_r == ST_FETCH;
	wire        in_exe  = st_r == ST_EXEC;
	wire [7:0]  opc     = mem_rdata;
	wire        f_pfx   = in_fet && run_r && !pfx_r && opc == OP_PFX;
	wire        f_tst   = in_fet && run_r && !pfx_r && opc == OP_FTEST;
	wire [15:0] idx     = pfx_r ? y_r : x_r;
	// Unsigned offset; the high byte never wraps into a signed value.
	wire [15:0] ea_ind  = idx + {8'h00, lo_r}; // see RULE_15
	wire [15:0] ea_ext  = {hi_r, lo_r}; // see RULE_16
	wire [15:0] ea_m    = is_ext ? ea_ext : ea_ind;
	wire [4:0]  push_k  = cyc_r - CYC_PUSH;

	// Total cycles and legality for the opcode in the fetch slot.
	function automatic logic [4:0] tot_of(input logic [7:0] o, input logic p);
		logic [4:0] t;
		t = 5'h00;
		case (o)
			OP_LDFLG, OP_STFLG, OP_CHKA, OP_CHKB: t = p ? 5'h00 : CYC_INH;
			OP_SPIX, OP_IXSP: t = p ? CYC_SPY : CYC_SPX; // see RULE_07
			OP_CHKI: t = p ? CYC_CHKY : CYC_CHKX; // see RULE_04
			OP_CHKE: t = p ? 5'h00 : CYC_CHKE;
			OP_HALT: t = p ? 5'h00 : CYC_STK;
			default: t = 5'h00;
		endcase
		return t;
	endfunction : tot_of

	wire [4:0] tot     = tot_of(op_r, pfx_r);
	wire [4:0] f_tot   = tot_of(opc, pfx_r);
	wire       f_ok    = in_fet && run_r && !f_pfx && !f_tst && f_tot != 5'h00;
	// Opcode 00 outside test mode is illegal, not an operation.
	wire       f_bad   = in_fet && run_r && !f_pfx && f_tot == 5'h00 && !(f_tst && tm_s2_r); // see RULE_12
	wire       done    = in_exe && cyc_r == tot;
	wire       is_ldf  = op_r == OP_LDFLG && !pfx_r;
	wire       is_stf  = op_r == OP_STFLG && !pfx_r;
	wire       is_ca   = op_r == OP_CHKA && !pfx_r;
	wire       is_cb   = op_r == OP_CHKB && !pfx_r;
	wire       is_spi  = op_r == OP_SPIX;
	wire       is_isp  = op_r == OP_IXSP;
	wire       rd_hi   = in_exe && is_ext && cyc_r == ol + 5'h01;
	wire       rd_lo   = in_exe && ((is_ext && cyc_r == ol + 5'h02)
	                     || (is_ind && cyc_r == ol + 5'h01));
	wire       rd_m    = in_exe && ((is_ext && cyc_r == ol + 5'h03)
	                     || (is_ind && cyc_r == ol + 5'h02));
	wire       push    = in_exe && is_halt && cyc_r >= CYC_PUSH && cyc_r < CYC_STK;

	// ==========================================
	// Stack byte order: return address, Y, X, A, B, flags.
	logic [7:0] push_b;
	always_comb
	begin
		case (push_k)
			5'h00:   push_b = pc_r[7:0];
			5'h01:   push_b = pc_r[15:8];
			5'h02:   push_b = y_r[7:0];
			5'h03:   push_b = y_r[15:8];
			5'h04:   push_b = x_r[7:0];
			5'h05:   push_b = x_r[15:8];
			5'h06:   push_b = a_r;
			5'h07:   push_b = b_r;
			default: push_b = flg_r;
		endcase
	end

	// ==========================================
	// Memory bus; the address is combinational so data returns in the same cycle.
	assign mem_rd    = in_fet || rd_hi || rd_lo || rd_m || st_r == ST_VEC;
	assign mem_we    = push; // see RULE_11
	assign mem_wdata = push_b;
	always_comb
	begin
		case (st_r)
			ST_FETCH: mem_addr = pc_r;
			ST_EXEC:  mem_addr = push ? sp_r : (rd_m ? ea_m : pc_r);
			ST_VEC:   mem_addr = VEC_ADDR + {15'h0000, cyc_r[0]}; // see RULE_11
			ST_TEST:  mem_addr = tad_r; // see RULE_13
			default:  mem_addr = pc_r;
		endcase
	end
	assign halted = st_r == ST_WAIT;

	// ==========================================
	// Zero and sign check result, shared by all three forms.
	wire [7:0] chk_v = is_ca ? a_r : (is_cb ? b_r : m_r);
	wire [7:0] chk_f = {flg_r[7:4], chk_v[7], chk_v == 8'h00, 2'b00};
	// The X mask bit only survives if it is already set and A keeps it.
	wire [7:0] ldf_f = {a_r[7], a_r[FB_X] & flg_r[FB_X], a_r[5:0]}; // see RULE_02

	// ==========================================
	// Sequencer next state
	always_comb
	begin
		st_nxt  = st_r;
		cyc_nxt = cyc_r;
		op_nxt  = op_r;
		pfx_nxt = pfx_r;
		tad_nxt = tad_r;
		bad_nxt = bad_r | f_bad;
		case (st_r)
			ST_FETCH:
			begin
				if (f_pfx)
				begin
					pfx_nxt = 1'b1;
					cyc_nxt = cyc_r + 5'h01;
				end
				else if (f_tst && tm_s2_r)
				begin
					st_nxt  = ST_TEST;
					tad_nxt = pc_r;
				end
				else if (f_ok)
				begin
					op_nxt  = opc;
					st_nxt  = ST_EXEC;
					cyc_nxt = cyc_r + 5'h01;
				end
				else if (f_bad)
				begin
					pfx_nxt = 1'b0;
					cyc_nxt = 5'h01;
				end
			end
			ST_EXEC:
			begin
				cyc_nxt = cyc_r + 5'h01;
				if (done)
				begin
					st_nxt  = is_halt ? ST_WAIT : ST_FETCH;
					cyc_nxt = 5'h01;
					pfx_nxt = 1'b0;
				end
			end
			ST_WAIT:
			begin
				if (irq_go)
				begin
					st_nxt  = ST_VEC;
					cyc_nxt = 5'h00;
				end
			end
			ST_VEC:
			begin
				cyc_nxt = cyc_r + 5'h01;
				if (cyc_r[0])
				begin
					st_nxt  = ST_FETCH;
					cyc_nxt = 5'h01;
				end
			end
			ST_TEST: tad_nxt = tad_r + 16'h0001; // see RULE_13
			default: st_nxt = ST_FETCH;
		endcase
	end

	// ==========================================
	// Datapath next values; a software write wins over the instruction.
	wire w_a  = sw_wr && reg_addr == RI_A;
	wire w_b  = sw_wr && reg_addr == RI_B;
	wire w_f  = sw_wr && reg_addr == RI_FLG;
	wire w_x  = sw_wr && reg_addr == RI_X;
	wire w_y  = sw_wr && reg_addr == RI_Y;
	wire w_sp = sw_wr && reg_addr == RI_SP;
	wire w_pc = sw_wr && reg_addr == RI_PC;

	assign a_nxt  = w_a ? reg_wdata[7:0] : ((done && is_stf) ? flg_r : a_r); // see RULE_03
	assign b_nxt  = w_b ? reg_wdata[7:0] : b_r;
	assign hi_nxt = rd_hi ? mem_rdata : hi_r; // see RULE_16
	assign lo_nxt = rd_lo ? mem_rdata : lo_r;
	assign m_nxt  = rd_m ? mem_rdata : m_r;
	assign x_nxt  = w_x ? reg_wdata : ((done && is_spi && !pfx_r) ? sp_r + 16'h0001 : x_r); // see RULE_07
	assign y_nxt  = w_y ? reg_wdata : ((done && is_spi && pfx_r) ? sp_r + 16'h0001 : y_r); // see RULE_08

	always_comb
	begin
		flg_nxt = flg_r;
		if (w_f)
			flg_nxt = reg_wdata[7:0];
		else if (done && is_ldf)
			flg_nxt = ldf_f; // see RULE_01
		else if (done && (is_ca || is_cb || is_ext || is_ind))
			flg_nxt = chk_f; // see RULE_04 see RULE_05 see RULE_06
		else if (st_r == ST_VEC && cyc_r[0])
			flg_nxt = flg_r | 8'h10;
	end

	always_comb
	begin
		sp_nxt = sp_r;
		if (w_sp)
			sp_nxt = reg_wdata;
		else if (push)
			sp_nxt = sp_r - 16'h0001;
		else if (done && is_isp)
			sp_nxt = idx - 16'h0001; // see RULE_09 see RULE_10
	end

	always_comb
	begin
		pc_nxt = pc_r;
		if (w_pc)
			pc_nxt = reg_wdata;
		else if ((in_fet && run_r) || rd_hi || rd_lo)
			pc_nxt = pc_r + 16'h0001;
		else if (st_r == ST_VEC && !cyc_r[0])
			pc_nxt = {mem_rdata, pc_r[7:0]};
		else if (st_r == ST_VEC)
			pc_nxt = {pc_r[15:8], mem_rdata};
	end

	// ==========================================
	// Registers
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			st_r  <= ST_FETCH;
			cyc_r <= 5'h01;
			pfx_r <= 1'b0;
			op_r  <= 8'h00;
			tad_r <= 16'h0000;
			bad_r <= 1'b0;
		end
		else
		begin
			st_r  <= st_nxt;
			cyc_r <= cyc_nxt;
			pfx_r <= pfx_nxt;
			op_r  <= op_nxt;
			tad_r <= tad_nxt;
			bad_r <= bad_nxt;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			a_r   <= 8'h00;
			b_r   <= 8'h00;
			flg_r <= RST_FLG;
			x_r   <= 16'h0000;
			y_r   <= 16'h0000;
			sp_r  <= RST_SP;
			pc_r  <= RST_PC;
		end
		else
		begin
			a_r   <= a_nxt;
			b_r   <= b_nxt;
			flg_r <= flg_nxt;
			x_r   <= x_nxt;
			y_r   <= y_nxt;
			sp_r  <= sp_nxt;
			pc_r  <= pc_nxt;
		end
	end

	always_ff @(posedge clk)
	begin
		hi_r <= hi_nxt;
		lo_r <= lo_nxt;
		m_r  <= m_nxt;
	end

	// ==========================================
	// Operand format evaluator, driven from software.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			run_r  <= 1'b0;
			fsel_r <= FM_DIR;
			fopd_r <= 16'h0000;
		end
		else
		begin
			run_r  <= (sw_wr && reg_addr == RI_CTRL) ? reg_wdata[0] : run_r;
			fsel_r <= (sw_wr && reg_addr == RI_FSEL) ? reg_wdata[2:0] : fsel_r;
			fopd_r <= (sw_wr && reg_addr == RI_FOPD) ? reg_wdata : fopd_r;
		end
	end

	wire [7:0]  f_lo   = fopd_r[7:0];
	wire [15:0] f_rel  = pc_r + {{8{f_lo[7]}}, f_lo}; // see RULE_18
	wire [7:0]  f_msk  = (a_r & ~f_lo) | (b_r & f_lo); // see RULE_19
	logic [15:0] fres;
	always_comb
	begin
		case (fsel_r)
			FM_DIR:  fres = {8'h00, f_lo}; // see RULE_14
			FM_IDX:  fres = x_r + {8'h00, f_lo}; // see RULE_15
			FM_IDY:  fres = y_r + {8'h00, f_lo};
			FM_EXT:  fres = fopd_r;
			FM_IMM:  fres = fopd_r; // see RULE_17
			FM_REL:  fres = f_rel;
			FM_MSK:  fres = {8'h00, f_msk};
			default: fres = 16'h0000;
		endcase
	end

	// ==========================================
	// Read port, data one cycle after the strobe; unmapped reads give zero.
	logic [15:0] rsel;
	always_comb
	begin
		case (reg_addr)
			RI_A:    rsel = {8'h00, a_r};
			RI_B:    rsel = {8'h00, b_r};
			RI_FLG:  rsel = {8'h00, flg_r};
			RI_X:    rsel = x_r;
			RI_Y:    rsel = y_r;
			RI_SP:   rsel = sp_r;
			RI_PC:   rsel = pc_r;
			RI_STAT: rsel = {9'h000, bad_r, tm_s2_r, st_r};
			RI_CTRL: rsel = {15'h0000, run_r};
			RI_FSEL: rsel = {13'h0000, fsel_r};
			RI_FOPD: rsel = fopd_r;
			RI_FRES: rsel = fres;
			default: rsel = 16'h0000;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			reg_rdata <= 16'h0000;
		else
			reg_rdata <= reg_rd ? rsel : 16'h0000;
	end

	// ==========================================
	// Checks
	ldf_mask_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_02
		done && is_ldf && !flg_r[FB_X] && !w_f |=> !flg_r[FB_X])
		else $error("X mask set by flag load");
	stf_copy_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_03
		done && is_stf && !w_a && !w_f |=> a_r == $past(flg_r) && flg_r == $past(flg_r))
		else $error("flag store wrong");
	chka_time_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_05
		f_ok && opc == OP_CHKA && !pfx_r |=> done ##1 in_fet)
		else $error("check A not two cycles");
	chk_flags_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_06
		done && is_cb && !w_f |=> !flg_r[FB_V] && !flg_r[FB_C] && flg_r[FB_Z] == ($past(b_r) == 8'h00))
		else $error("check B flags wrong");
	spix_val_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_07
		f_ok && opc == OP_SPIX && !pfx_r && !w_sp |=> !done ##1 done && !w_x ##1 x_r == $past(sp_r) + 16'h0001)
		else $error("SP to X wrong");
	ixsp_val_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_09
		done && is_isp && !pfx_r && !w_sp |=> sp_r == $past(x_r) - 16'h0001)
		else $error("X to SP wrong");
	halt_stack_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_11
		f_ok && opc == OP_HALT && !pfx_r |-> ##12 halted)
		else $error("halt stacking not twelve cycles");
	test_inc_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_13
		st_r == ST_TEST |=> st_r == ST_TEST && mem_addr == $past(mem_addr) + 16'h0001)
		else $error("test address not incrementing");
	dir_fmt_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_14
		fsel_r == FM_DIR |-> fres[15:8] == 8'h00)
		else $error("direct high byte not zero");

endmodule : cttw_core

// ===== tb/cttw_mem_model.sv
// Behavioural program memory standing on the sequencer's memory bus.
module cttw_mem_model
(
	// Clock
	input  wire logic        clk,
	// Memory bus
	input  wire logic [15:0] mem_addr,
	input  wire logic        mem_rd,
	input  wire logic        mem_we,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] mem [0:65535];

	// ==========================================
	// Storage
	// Outside read cycles the bus shows the inverse, so a stale byte never passes for data.
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];

	// Stacking writes land one byte per cycle.
	always @(posedge clk)
	begin
		if (mem_we)
			mem[mem_addr] <= mem_wdata;
	end

	// A fill pattern keeps unused reads defined.
	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'(i) ^ 8'hA5;
	end
endmodule : cttw_mem_model

// ===== tb/cttw_core_tb.sv
// Self-checking testbench for the transfer, test and wait sequencer.
module cttw_core_tb
	import cttw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================
	// Signals
	localparam logic [15:0] VEC = 16'hFFF2;
	logic        clk = 1'b0, resetn = 1'b0, irq_n_pin = 1'b1, test_mode_pin = 1'b0;
	logic        reg_wr = 1'b0, reg_rd = 1'b0, mem_rd, mem_we, halted;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, mem_addr, rv, p1, p2;
	logic [7:0]  mem_wdata, mem_rdata, a, b, f, m, lo, na, nb, nf;
	logic [15:0] x, y, sp, nx, ny, nsp;
	int          miscompares = 0, comparisons = 0, n;
	integer      seed = 32'h4dba3688;

	always #20 clk = ~clk;

	cttw_core #(.VEC_ADDR(VEC)) DUT (.clk(clk), .resetn(resetn), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .irq_n_pin(irq_n_pin),
		.test_mode_pin(test_mode_pin), .halted(halted), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	cttw_mem_model MEM (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_we(mem_we),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	// ==========================================
	// Helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	task automatic wr(input logic [3:0] ad, input logic [15:0] d);
		@(posedge clk);
		reg_addr  <= ad;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic rd(input logic [3:0] ad, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= ad;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	task automatic rst();
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
	endtask : rst

	// Round 0 and 1 force the zero, sign and X-mask-never-set corners.
	task automatic init(input int r);
		a  = 8'($random(seed));
		b  = 8'($random(seed));
		f  = 8'($random(seed));
		m  = 8'($random(seed));
		lo = 8'($random(seed));
		x  = {4'h2, 12'($random(seed))};
		y  = {4'h2, 12'($random(seed))};
		sp = {4'h1, 12'($random(seed))};
		if (r == 0)
		begin
			a = 8'h00;
			b = 8'h00;
			m = 8'h00;
		end
		if (r == 1)
		begin
			a = 8'hC0;
			b = 8'h80;
			m = 8'h80;
			lo = 8'hFF;
			f[FB_X] = 1'b0;
		end
		{na, nb, nf, nx, ny, nsp} = {a, b, f, x, y, sp};
	endtask : init

	function automatic logic [7:0] nz(input logic [7:0] fl, input logic [7:0] v);
		return {fl[7:4], v[7], v == 8'h00, 2'b00};
	endfunction : nz

	function automatic logic [15:0] fexp(input logic [2:0] fm, input logic [15:0] o);
		case (fm)
			FM_DIR:  return {8'h00, o[7:0]};
			FM_IDX:  return x + {8'h00, o[7:0]};
			FM_IDY:  return y + {8'h00, o[7:0]};
			FM_EXT:  return o;
			FM_IMM:  return o;
			FM_REL:  return sp + {{8{o[7]}}, o[7:0]};
			default: return {8'h00, (a & ~o[7:0]) | (b & o[7:0])};
		endcase
	endfunction : fexp

	// Runs one instruction followed by a halt; the halt's stack frame shows the state left behind.
	task automatic run_prog(input logic [7:0] p0, p1, p2, input int len, input int cyc);
		logic [7:0]  e [9];
		logic [15:0] pc;
		rst();
		{MEM.mem[0], MEM.mem[1], MEM.mem[2]} = {p0, p1, p2};
		MEM.mem[len] = OP_HALT;
		wr(RI_A, {8'h00, a});
		wr(RI_B, {8'h00, b});
		wr(RI_FLG, {8'h00, f});
		wr(RI_X, x);
		wr(RI_Y, y);
		wr(RI_SP, sp);
		wr(RI_PC, 16'h0000);
		wr(RI_CTRL, 16'h0001);
		n = 0;
		#1;
		while (halted !== 1'b1 && n < 80)
		begin
			@(posedge clk);
			#1 n++;
		end
		chk(16'(n), 16'(cyc + 12), "cycles to halt");
		pc = 16'(len + 1);
		e = '{pc[7:0], pc[15:8], ny[7:0], ny[15:8], nx[7:0], nx[15:8], na, nb, nf};
		for (int i = 0; i < 9; i++)
			chk({8'h00, MEM.mem[nsp - 16'(i)]}, {8'h00, e[i]}, "stacked byte");
		rd(RI_STAT, rv);
		chk({11'h000, rv[4:0]}, 16'h0004, "halt state");
	endtask : run_prog

	// ==========================================
	// Watchdog
	initial
	begin
		#800000;
		miscompares++;
		conclude();
	end

	// ==========================================
	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		rd(RI_FLG, rv);
		chk(rv, {8'h00, RST_FLG}, "flag reset");
		rd(RI_SP, rv);
		chk(rv, RST_SP, "stack reset");
		for (int r = 0; r < 4; r++)
		begin
			init(r);
			na = f;
			run_prog(OP_STFLG, 8'h00, 8'h00, 1, 2);
			init(r);
			nf = a;
			nf[FB_X] = a[FB_X] & f[FB_X];
			run_prog(OP_LDFLG, 8'h00, 8'h00, 1, 2);
			init(r);
			nf = nz(f, a);
			run_prog(OP_CHKA, 8'h00, 8'h00, 1, 2);
			init(r);
			nf = nz(f, b);
			run_prog(OP_CHKB, 8'h00, 8'h00, 1, 2);
			init(r);
			nx = sp + 16'h0001;
			run_prog(OP_SPIX, 8'h00, 8'h00, 1, 3);
			init(r);
			ny = sp + 16'h0001;
			run_prog(OP_PFX, OP_SPIX, 8'h00, 2, 4);
			init(r);
			nsp = x - 16'h0001;
			run_prog(OP_IXSP, 8'h00, 8'h00, 1, 3);
			init(r);
			nsp = y - 16'h0001;
			run_prog(OP_PFX, OP_IXSP, 8'h00, 2, 4);
			init(r);
			MEM.mem[{8'h40, lo}] = m;
			nf = nz(f, m);
			run_prog(OP_CHKE, 8'h40, lo, 3, 6);
			init(r);
			MEM.mem[x + {8'h00, lo}] = m;
			nf = nz(f, m);
			run_prog(OP_CHKI, lo, 8'h00, 2, 6);
			init(r);
			MEM.mem[y + {8'h00, lo}] = m;
			nf = nz(f, m);
			run_prog(OP_PFX, OP_CHKI, lo, 3, 7);
		end
		// Opcode 00 outside test mode is refused in one cycle.
		init(2);
		run_prog(OP_FTEST, 8'h00, 8'h00, 1, 1);
		rd(RI_STAT, rv);
		chk({15'h0000, rv[6]}, 16'h0001, "illegal flag");
		// Wake from halt: two vector reads, then the fetch at the vector target.
		init(2);
		f[FB_I] = 1'b0;
		nf = nz(f, a);
		{MEM.mem[VEC], MEM.mem[VEC + 16'h0001], MEM.mem[16'h0600]} = {8'h06, 8'h00, OP_HALT};
		run_prog(OP_CHKA, 8'h00, 8'h00, 1, 2);
		@(posedge clk);
		irq_n_pin <= 1'b0;
		{n, p1, p2} = 0;
		#1;
		while (!(mem_rd === 1'b1 && mem_addr === 16'h0600) && n < 40)
		begin
			if (mem_rd === 1'b1)
				{p2, p1} = {p1, mem_addr};
			@(posedge clk);
			#1 n++;
		end
		chk(p2, VEC, "vector high read");
		chk(p1, VEC + 16'h0001, "vector low read");
		@(posedge clk);
		irq_n_pin <= 1'b1;
		rd(RI_FLG, rv);
		chk({15'h0000, rv[FB_I]}, 16'h0001, "mask after wake");
		// Test opcode in test mode walks the address bus until reset.
		@(posedge clk);
		test_mode_pin <= 1'b1;
		rst();
		MEM.mem[0] = OP_FTEST;
		wr(RI_PC, 16'h0000);
		wr(RI_CTRL, 16'h0001);
		n = 0;
		#1;
		while (mem_addr !== 16'h0001 && n < 10)
		begin
			@(posedge clk);
			#1 n++;
		end
		for (int k = 1; k < 21; k++)
		begin
			chk(mem_addr, 16'(k), "test address walk");
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		test_mode_pin <= 1'b0;
		rst();
		// Operand formats over random and boundary operands.
		for (int k = 0; k < 28; k++)
		begin
			init(k / 7);
			wr(RI_A, {8'h00, a});
			wr(RI_B, {8'h00, b});
			wr(RI_X, x);
			wr(RI_Y, y);
			wr(RI_PC, sp);
			rv = (k / 7 == 1) ? 16'hFF80 : 16'($random(seed));
			wr(RI_FSEL, 16'(k % 7));
			wr(RI_FOPD, rv);
			rd(RI_FRES, p1);
			chk(p1, fexp(3'(k % 7), rv), "format result");
		end
		conclude();
	end
endmodule : cttw_core_tb
